// [rtl/ddcs_map.svh]
`ifndef DDCS_MAP_SVH
`define DDCS_MAP_SVH

// Register offsets on the special function register port.
`define DDCS_OFS_WINDOW   8'hd4
`define DDCS_OFS_TXBYTE   8'hd5
`define DDCS_OFS_PTR      8'hd6
`define DDCS_OFS_CTRL     8'hd7

// Field positions inside channel_control.
`define DDCS_BIT_SIZE     6
`define DDCS_BIT_MANUAL   5
`define DDCS_BIT_AMASK    4
`define DDCS_BIT_LIRQ     3
`define DDCS_BIT_LEN      2
`define DDCS_BIT_SWIRQ    1
`define DDCS_BIT_PROTO    0

// Reset values.
`define DDCS_RST_TXBYTE   8'h00
`define DDCS_RST_PTR      8'h00
`define DDCS_RST_CTRL     8'h00

// Default display address (upper seven bits) and the masked upper nibble.
`define DDCS_ADDR_DEFAULT 7'h50
`define DDCS_ADDR_AX_HI   4'ha

// Upper address byte of the buffer page in external data space.
`define DDCS_XDATA_PAGE   8'hff

// Index of the ninth legacy clock pulse in a byte period, counted from zero.
`define DDCS_LINK_LAST    4'h8
`define DDCS_LINK_MSB     4'h7

`endif

// [rtl/ddcs_pkg.sv]
package ddcs_pkg;

  // Phases of the legacy transmit engine.
  typedef enum logic [0:0] {
    DDCS_LNK_INIT,
    DDCS_LNK_SEND
  } ddcs_link_state_t;

endpackage : ddcs_pkg

// [rtl/ddcs_link.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ddcs_map.svh"

module ddcs_link (
  // Legacy clock domain.
  input  wire logic       vclk_in,
  input  wire logic       run_b_in,
  // Byte to send, held steady by the core for a whole byte period.
  input  wire logic [7:0] byte_in,
  // Reload event toward the core, and the open-drain data enable.
  output logic            req_tog_out,
  output logic            sda_oe_out
);

  logic                       lrst1_r;   // First reset release flop.
  logic                       lrst_b_r;  // Reset copy used by the engine.
  ddcs_pkg::ddcs_link_state_t st_r;      // Engine phase.
  ddcs_pkg::ddcs_link_state_t st_nxt;
  logic [3:0]                 cnt_r;     // Pulse counter within a byte period.
  logic [3:0]                 cnt_nxt;
  logic [7:0]                 sh_r;      // Byte being shifted out.
  logic [7:0]                 sh_nxt;
  logic                       tog_r;     // Toggles once per reload pulse.
  logic                       tog_nxt;
  logic                       oe_r;      // High while the pin is pulled low.
  logic                       oe_nxt;

  // Reset asserts at once but releases on legacy clock edges, so the first
  // counted pulse is a whole one.
  always_ff @(posedge vclk_in or negedge run_b_in) begin
    if (!run_b_in) begin
      lrst1_r  <= 1'b0;
      lrst_b_r <= 1'b0;
    end else begin
      lrst1_r  <= 1'b1;
      lrst_b_r <= lrst1_r;
    end
  end

  // Next state of the engine; the pin is released in the init phase and on
  // every ninth pulse, and bits go out most significant first.
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    tog_nxt = tog_r;
    oe_nxt  = 1'b0;
    if (cnt_r == `DDCS_LINK_LAST) begin
      cnt_nxt = 4'h0;
      sh_nxt  = byte_in;  // The core left this word steady for eight pulses.
      tog_nxt = ~tog_r;
      st_nxt  = ddcs_pkg::DDCS_LNK_SEND;
    end else begin
      cnt_nxt = 4'(cnt_r + 4'h1);
      case (st_r)
        ddcs_pkg::DDCS_LNK_INIT: begin
          oe_nxt = 1'b0;  // High impedance during synchronisation.
        end
        ddcs_pkg::DDCS_LNK_SEND: begin
          oe_nxt = ~sh_r[3'(`DDCS_LINK_MSB - cnt_r)];  // One bit per pulse.
        end
        default: begin
          st_nxt = ddcs_pkg::DDCS_LNK_INIT;
        end
      endcase
    end
  end

  // Engine registers.
  always_ff @(posedge vclk_in or negedge lrst_b_r) begin
    if (!lrst_b_r) begin
      st_r  <= ddcs_pkg::DDCS_LNK_INIT;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      tog_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      tog_r <= tog_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign req_tog_out = tog_r;
  assign sda_oe_out  = oe_r;

  sequence s_ninth;
    cnt_r == `DDCS_LINK_LAST;
  endsequence

  chk_init_quiet: assert property (@(posedge vclk_in) disable iff (!lrst_b_r)
    (st_r == ddcs_pkg::DDCS_LNK_INIT) |-> !oe_r)
    else $error("Data pin driven during init.");

  chk_reload_pulse: assert property (@(posedge vclk_in) disable iff (!lrst_b_r)
    s_ninth |=> (!oe_r && (tog_r != $past(tog_r)) && (cnt_r == 4'h0)))
    else $error("Ninth pulse did not reload.");

endmodule : ddcs_link
`default_nettype wire

// [rtl/ddcs_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ddcs_map.svh"

module ddcs_top (
  // Clock, reset and the legacy clock from the vertical sync pin.
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        vclk_in,
  // Special function register port.
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic [7:0]       sfr_rdata_out,
  // External data space port for the buffer page.
  input  wire logic [15:0] xd_addr_in,
  input  wire logic        xd_wr_in,
  input  wire logic        xd_rd_in,
  input  wire logic [7:0]  xd_wdata_in,
  output logic [7:0]       xd_rdata_out,
  output logic             xd_hit_out,
  // Side band toward the serial bus engine.
  input  wire logic        i2c_enable_in,
  input  wire logic        i2c_addr_valid_in,
  input  wire logic [7:0]  i2c_addr_byte_in,
  output logic             i2c_addr_match_out,
  input  wire logic        i2c_tx_req_in,
  output logic [7:0]       i2c_tx_data_out,
  input  wire logic        i2c_rx_valid_in,
  input  wire logic        i2c_rx_first_in,
  input  wire logic [7:0]  i2c_rx_data_in,
  output logic             i2c_manual_out,
  // Legacy data pin, open drain, and the two service requests.
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             legacy_byte_irq_out,
  output logic             mode_switch_irq_out
);

  logic       rst1_r;             // First reset release flop.
  logic       rst_b_r;            // Released reset used everywhere below.
  logic [7:0] mem_r [0:255];      // Identification buffer.
  logic       mem_we;             // Buffer write strobe this cycle.
  logic [7:0] mem_wa;             // Buffer write index.
  logic [7:0] mem_wd;             // Buffer write data.
  logic [7:0] mem_at_ptr;         // Buffer byte at the pointer.
  logic [7:0] ptr_r, ptr_nxt;     // buffer_pointer.
  logic [7:0] txb_r, txb_nxt;     // legacy_tx_byte.
  logic       size_r, size_nxt;   // buffer_size_select.
  logic       man_r, man_nxt;     // manual_transfer_enable.
  logic       amask_r, amask_nxt; // address_mask_enable.
  logic       lirq_r, lirq_nxt;   // legacy_byte_irq_flag.
  logic       len_r, len_nxt;     // legacy_mode_enable.
  logic       swirq_r, swirq_nxt; // mode_switch_irq.
  logic       mode_r, mode_nxt;   // current_protocol_flag.
  logic       len_d_r;            // Enable of the previous cycle, for the rising edge.
  logic       run_r;              // Keeps the legacy engine out of reset.
  logic [7:0] rdata_r, rdata_nxt; // Register read data.
  logic [7:0] xrd_r, xrd_nxt;     // External read data.
  logic [7:0] itx_r, itx_nxt;     // Byte for the serial bus engine.
  logic       tog_raw;            // Reload toggle from the legacy domain.
  logic       tog1_r, tog2_r, tog3_r, seen_r; // Toggle synchroniser.
  logic       link_evt;           // One cycle per ninth legacy pulse.
  logic       len_rise;           // Legacy enable just went high.
  logic       addr_hit;           // Address byte matches.
  logic       go_ddc2;            // Switch into DDC2b this cycle.
  logic       sfr_wr_win, sfr_rd_win, sfr_wr_ctrl;

  // Control reset word held as a constant, so its bits can be picked out.
  localparam logic [7:0] ctrl_rst = `DDCS_RST_CTRL;

  // Pointer step; with the small buffer the upper half is left to software
  // and the post increment wraps the low seven bits and keeps bit 7.
  function automatic logic [7:0] ddcs_step(input logic [7:0] p, input logic big);
    ddcs_step = big ? 8'(p + 8'h01) : {p[7], 7'(p[6:0] + 7'h01)};
  endfunction : ddcs_step

  // Display address compare, either exact or with the low bits ignored.
  function automatic logic ddcs_match(input logic [7:0] a, input logic msk);
    ddcs_match = msk ? (a[7:4] == `DDCS_ADDR_AX_HI)
                     : (a[7:1] == `DDCS_ADDR_DEFAULT);
  endfunction : ddcs_match

  // Reset is taken at once and released through two flops.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst1_r  <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst1_r  <= 1'b1;
      rst_b_r <= rst1_r;
    end
  end

  // The reload toggle crosses on three flops; it counts once the second and
  // third agree, and the first is read by nothing else.
  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      tog1_r <= 1'b0;
      tog2_r <= 1'b0;
      tog3_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      tog1_r <= tog_raw;
      tog2_r <= tog1_r;
      tog3_r <= tog2_r;
      seen_r <= tog3_r;
    end
  end

  assign link_evt    = (tog2_r == tog3_r) && (tog3_r != seen_r);
  assign len_rise    = len_r && !len_d_r;
  assign mem_at_ptr  = mem_r[ptr_r];
  assign addr_hit    = ddcs_match(i2c_addr_byte_in, amask_r);
  assign go_ddc2     = !mode_r && i2c_enable_in && i2c_addr_valid_in && addr_hit;
  assign sfr_wr_win  = sfr_wr_in && (sfr_addr_in == `DDCS_OFS_WINDOW);
  assign sfr_rd_win  = sfr_rd_in && (sfr_addr_in == `DDCS_OFS_WINDOW);
  assign sfr_wr_ctrl = sfr_wr_in && (sfr_addr_in == `DDCS_OFS_CTRL);

  // Next values of registers, pointer and buffer write port. When several
  // pointer users collide in one cycle the later branch wins, except that a window
  // write holds off a received serial data byte; software is expected not to touch
  // the window while the unit runs automatically.
  always_comb begin
    ptr_nxt   = ptr_r;
    txb_nxt   = txb_r;
    size_nxt  = size_r;
    man_nxt   = man_r;
    amask_nxt = amask_r;
    len_nxt   = len_r;
    rdata_nxt = rdata_r;
    xrd_nxt   = xrd_r;
    itx_nxt   = itx_r;
    mem_we    = 1'b0;
    mem_wa    = ptr_r;
    mem_wd    = sfr_wdata_in;
    // Flags: a clearing write takes only bits written as zero, and a set in
    // the same cycle still wins.
    lirq_nxt  = lirq_r & ~(sfr_wr_ctrl & ~sfr_wdata_in[`DDCS_BIT_LIRQ]);
    swirq_nxt = swirq_r & ~(sfr_wr_ctrl & ~sfr_wdata_in[`DDCS_BIT_SWIRQ]);
    mode_nxt  = mode_r;
    // Register reads answer one cycle later; unmapped offsets read zero.
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        `DDCS_OFS_WINDOW: rdata_nxt = mem_at_ptr;
        `DDCS_OFS_TXBYTE: rdata_nxt = txb_r;
        `DDCS_OFS_PTR:    rdata_nxt = ptr_r;
        `DDCS_OFS_CTRL:   rdata_nxt = {1'b0, size_r, man_r, amask_r,
                                       lirq_r, len_r, swirq_r, mode_r};
        default:          rdata_nxt = 8'h00;
      endcase
    end
    if (sfr_wr_win) begin
      mem_we = 1'b1;  // Written where the pointer stands.
    end
    if (sfr_wr_win || sfr_rd_win) begin
      ptr_nxt = ddcs_step(ptr_r, size_r);
    end
    if (sfr_wr_in && (sfr_addr_in == `DDCS_OFS_TXBYTE)) begin
      txb_nxt = sfr_wdata_in;
    end
    if (sfr_wr_in && (sfr_addr_in == `DDCS_OFS_PTR)) begin
      ptr_nxt = sfr_wdata_in;
    end
    if (sfr_wr_ctrl) begin
      size_nxt  = sfr_wdata_in[`DDCS_BIT_SIZE];
      man_nxt   = sfr_wdata_in[`DDCS_BIT_MANUAL];
      amask_nxt = sfr_wdata_in[`DDCS_BIT_AMASK];
      len_nxt   = sfr_wdata_in[`DDCS_BIT_LEN];
    end
    // External data space reaches the buffer only in manual mode.
    if (man_r && (xd_addr_in[15:8] == `DDCS_XDATA_PAGE)) begin
      if (xd_rd_in) begin
        xrd_nxt = mem_r[xd_addr_in[7:0]];
      end
      if (xd_wr_in && !sfr_wr_win) begin
        mem_we = 1'b1;
        mem_wa = xd_addr_in[7:0];
        mem_wd = xd_wdata_in;
      end
    end
    // Legacy byte service: in automatic mode prefetch on enable, then on each ninth pulse.
    if (len_r && !mode_r && (link_evt || len_rise)) begin
      if (!man_r) begin
        txb_nxt = mem_at_ptr;
        ptr_nxt = ddcs_step(ptr_r, size_r);
      end else if (link_evt) begin
        lirq_nxt = 1'b1;  // Software loads the next byte.
      end
    end
    // Serial bus engine: in manual mode it keeps bytes in its own shift
    // register and the buffer is left alone.
    if (i2c_enable_in && !man_r) begin
      if (i2c_tx_req_in) begin
        itx_nxt = mem_at_ptr;
        ptr_nxt = ddcs_step(ptr_r, size_r);
      end else if (i2c_rx_valid_in && i2c_rx_first_in) begin
        ptr_nxt = i2c_rx_data_in;
      end else if (i2c_rx_valid_in && !sfr_wr_win && !mem_we) begin
        mem_we  = 1'b1;
        mem_wd  = i2c_rx_data_in;
        ptr_nxt = ddcs_step(ptr_r, size_r);
      end
    end
    // Protocol flag: DDC2b is entered on a matching address and left only
    // when both protocols are disabled.
    if (!len_nxt && !i2c_enable_in) begin
      mode_nxt = 1'b0;
    end else if (go_ddc2) begin
      mode_nxt  = 1'b1;
      swirq_nxt = 1'b1;
    end
  end

  // Control and data registers.
  always_ff @(posedge mclk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ptr_r   <= `DDCS_RST_PTR;
      txb_r   <= `DDCS_RST_TXBYTE;
      size_r  <= ctrl_rst[`DDCS_BIT_SIZE];
      man_r   <= ctrl_rst[`DDCS_BIT_MANUAL];
      amask_r <= ctrl_rst[`DDCS_BIT_AMASK];
      lirq_r  <= ctrl_rst[`DDCS_BIT_LIRQ];
      len_r   <= ctrl_rst[`DDCS_BIT_LEN];
      swirq_r <= ctrl_rst[`DDCS_BIT_SWIRQ];
      mode_r  <= ctrl_rst[`DDCS_BIT_PROTO];
      len_d_r <= 1'b0;
      run_r   <= 1'b0;
      rdata_r <= 8'h00;
      xrd_r   <= 8'h00;
      itx_r   <= 8'h00;
    end else begin
      ptr_r   <= ptr_nxt;
      txb_r   <= txb_nxt;
      size_r  <= size_nxt;
      man_r   <= man_nxt;
      amask_r <= amask_nxt;
      lirq_r  <= lirq_nxt;
      len_r   <= len_nxt;
      swirq_r <= swirq_nxt;
      mode_r  <= mode_nxt;
      len_d_r <= len_r;
      run_r   <= len_nxt && !mode_nxt;  // Clock ignored when disabled.
      rdata_r <= rdata_nxt;
      xrd_r   <= xrd_nxt;
      itx_r   <= itx_nxt;
    end
  end

  // Buffer storage has no reset; its content is undefined until loaded.
  always_ff @(posedge mclk_in) begin
    if (mem_we) begin
      mem_r[mem_wa] <= mem_wd;
    end
  end

  // Legacy engine on the vertical sync clock; held in reset unless enabled and not in DDC2b.
  ddcs_link u_link (
    .vclk_in     (vclk_in),
    .run_b_in    (run_r),
    .byte_in     (txb_r),
    .req_tog_out (tog_raw),
    .sda_oe_out  (sda_oe_out)
  );

  assign sda_out             = 1'b0;
  assign sfr_rdata_out       = rdata_r;
  assign xd_rdata_out        = xrd_r;
  assign xd_hit_out          = man_r && (xd_addr_in[15:8] == `DDCS_XDATA_PAGE);
  assign i2c_addr_match_out  = i2c_enable_in && addr_hit;
  assign i2c_tx_data_out     = itx_r;
  assign i2c_manual_out      = man_r;
  assign legacy_byte_irq_out = lirq_r;
  assign mode_switch_irq_out = swirq_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_r);

  logic solo_win;  // Window read with no other pointer user.
  assign solo_win = sfr_rd_win && !link_evt && !len_rise && !i2c_tx_req_in && !i2c_rx_valid_in;

  chk_window_step: assert property (solo_win |=> ptr_r == ddcs_step($past(ptr_r), size_r))
    else $error("Pointer did not step after window read.");
  chk_manual_flag: assert property (link_evt && man_r && len_r && !mode_r |=> lirq_r)
    else $error("Manual byte flag not raised.");
  chk_flag_hold: assert property (lirq_r && !sfr_wr_ctrl |=> lirq_r)
    else $error("Legacy flag cleared by hardware.");
  chk_switch_flag: assert property (go_ddc2 |=> mode_r && swirq_r)
    else $error("Switch to DDC2b not flagged.");
  chk_mode_sticky: assert property (mode_r && (len_nxt || i2c_enable_in) |=> mode_r)
    else $error("Left DDC2b while enabled.");
  chk_xdata_gate: assert property (!man_r |-> !xd_hit_out)
    else $error("Buffer visible in automatic mode.");
  chk_proto_read: assert property (sfr_rd_in && sfr_addr_in == `DDCS_OFS_CTRL
    |=> sfr_rdata_out[0] == $past(mode_r))
    else $error("Protocol bit misreported.");
  chk_addr_exact: assert property (!amask_r && i2c_addr_byte_in[7:1] != 7'h50
    |-> !i2c_addr_match_out)
    else $error("Foreign address accepted.");
  chk_addr_masked: assert property (amask_r && i2c_enable_in && i2c_addr_byte_in[7:4] == 4'ha
    |-> i2c_addr_match_out)
    else $error("Masked address refused.");
  chk_auto_fetch: assert property (link_evt && !man_r && len_r && !mode_r && !sfr_wr_in
    |=> txb_r == $past(mem_at_ptr))
    else $error("Automatic fetch missed.");

endmodule : ddcs_top
`default_nettype wire

// [sim/ddcs_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module ddcs_host_model (
  // Legacy clock toward the display and the pulled-up data wire.
  output var logic vclk_out,
  input  wire logic sda_in
);
  logic [7:0] rx_byte;  // Bits seen on frame edges 10 to 17, first bit ends on top.
  logic       init_low; // Set if the wire went low while it had to stay released.
  int         edge_cnt; // Rising edges since the frame was last cleared.

  initial begin
    vclk_out = 1'b0;
    rx_byte  = 8'h00;
    init_low = 1'b0;
    edge_cnt = 0;
  end

  // Starts a new frame count.
  task automatic clear_frame();
    edge_cnt = 0;
    init_low = 1'b0;
  endtask : clear_frame

  // Sends n pulses, one every 500 ns; the clock rests low between pulses so
  // the core has time to serve every reload across the crossing.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      #24 vclk_out = 1'b1;
      edge_cnt++;
      #24 vclk_out = 1'b0;
      // Sampled 24 ns after the launching edge, on the falling edge, once settled.
      if ((edge_cnt <= 9 || edge_cnt == 18) && sda_in !== 1'b1) begin
        init_low = 1'b1;
      end
      if (edge_cnt >= 10 && edge_cnt <= 17) begin
        rx_byte = {rx_byte[6:0], sda_in};
      end
      #452;
    end
  endtask : pulses
endmodule : ddcs_host_model

`default_nettype wire

// [sim/test_display_data_channel_slave.sv]
`timescale 1ns/1ns
`default_nettype none

module test_display_data_channel_slave;
  logic        mclk_in = 1'b0;
  logic        rst_b   = 1'b0;
  logic        vclk;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [15:0] xd_addr = 16'h0000;
  logic [7:0]  xd_wdata = 8'h00, xd_rdata;
  logic        xd_wr = 1'b0, xd_rd = 1'b0, xd_hit;
  logic        i2c_en = 1'b0, av = 1'b0, txr = 1'b0, rxv = 1'b0, rxf = 1'b0;
  logic [7:0]  ab = 8'h00, rxd = 8'h00, tx_data;
  logic        match, manual, sda_o, sda_oe, lirq, swirq;
  wire         sda_w = sda_oe ? sda_o : 1'b1; // Pull-up when released.
  int          error_cnt = 0, samples_checked = 0, cycles = 0;

  always #25 mclk_in = ~mclk_in;

  ddcs_top i_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b), .vclk_in(vclk),
    .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
    .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata),
    .xd_addr_in(xd_addr), .xd_wr_in(xd_wr), .xd_rd_in(xd_rd), .xd_wdata_in(xd_wdata),
    .xd_rdata_out(xd_rdata), .xd_hit_out(xd_hit),
    .i2c_enable_in(i2c_en), .i2c_addr_valid_in(av), .i2c_addr_byte_in(ab),
    .i2c_addr_match_out(match), .i2c_tx_req_in(txr), .i2c_tx_data_out(tx_data),
    .i2c_rx_valid_in(rxv), .i2c_rx_first_in(rxf), .i2c_rx_data_in(rxd),
    .i2c_manual_out(manual), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .legacy_byte_irq_out(lirq), .mode_switch_irq_out(swirq));

  ddcs_host_model i_host (.vclk_out(vclk), .sda_in(sda_w));

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Cuts a hang short.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One strobed access, register port (x=0) or external port (x=1).
  task automatic bus(input logic x, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    if (x) begin
      xd_addr = a;
      xd_wdata = d;
      xd_wr = w;
      xd_rd = !w;
    end else begin
      sfr_addr = a[7:0];
      sfr_wdata = d;
      sfr_wr = w;
      sfr_rd = !w;
    end
    @(negedge mclk_in);
    {xd_wr, xd_rd, sfr_wr, sfr_rd} = 4'h0;
  endtask : bus

  task automatic rd(input logic x, input logic [15:0] a, input logic [7:0] e);
    bus(x, 1'b0, a, 8'h00);
    check(x ? xd_rdata : sfr_rdata, e);
  endtask : rd

  // Presents a received address byte for one cycle and checks the match.
  task automatic addr(input logic [7:0] b, input logic e);
    @(negedge mclk_in);
    av = 1'b1;
    ab = b;
    #1 check({7'h00, match}, {7'h00, e});
    @(negedge mclk_in);
    av = 1'b0;
  endtask : addr

  initial begin
    repeat (16) @(negedge mclk_in);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk_in);
    rd(0, 'h00d5, 8'h00);
    rd(0, 'h00d6, 8'h00);
    rd(0, 'h00d7, 8'h00);
    rd(0, 'h00d3, 8'h00);
    bus(0, 1, 'h00d5, 8'ha5);
    rd(0, 'h00d5, 8'ha5);
    bus(1, 1, 'hff10, 8'h00);
    check({7'h00, xd_hit}, 8'h00);
    bus(0, 1, 'h00d7, 8'h20);
    check({7'h00, xd_hit}, 8'h01);
    check({7'h00, manual}, 8'h01);
    for (int i = 0; i < 4; i++) bus(1, 1, 16'(16'hff00 + i), 8'(8'h30 + i));
    bus(1, 1, 'hff7f, 8'h77);
    rd(1, 'hff02, 8'h32);
    $display("Test registers and buffer port done");
    bus(0, 1, 'h00d6, 8'h01);
    rd(0, 'h00d4, 8'h31);
    rd(0, 'h00d4, 8'h32);
    bus(0, 1, 'h00d4, 8'h9c);
    rd(1, 'hff03, 8'h9c);
    rd(0, 'h00d6, 8'h04);
    bus(0, 1, 'h00d6, 8'h7f);
    rd(0, 'h00d4, 8'h77);
    rd(0, 'h00d6, 8'h00);
    bus(0, 1, 'h00d7, 8'h60);
    bus(0, 1, 'h00d6, 8'h7f);
    rd(0, 'h00d4, 8'h77);
    rd(0, 'h00d6, 8'h80);
    $display("Test window pointer done");
    bus(0, 1, 'h00d7, 8'h20);
    bus(0, 1, 'h00d6, 8'h00);
    i_host.pulses(9);
    rd(0, 'h00d7, 8'h20);
    rd(0, 'h00d6, 8'h00);
    bus(0, 1, 'h00d7, 8'h04);
    i_host.pulses(2);
    i_host.clear_frame();
    i_host.pulses(18);
    repeat (8) @(negedge mclk_in);
    check(i_host.rx_byte, 8'h30);
    check({7'h00, i_host.init_low}, 8'h00);
    rd(0, 'h00d6, 8'h03);
    rd(0, 'h00d5, 8'h32);
    rd(0, 'h00d7, 8'h04);
    $display("Test legacy auto done");
    bus(0, 1, 'h00d7, 8'h20);
    bus(0, 1, 'h00d7, 8'h24);
    i_host.pulses(2);
    i_host.clear_frame();
    i_host.pulses(8);
    repeat (8) @(negedge mclk_in);
    rd(0, 'h00d7, 8'h24);
    i_host.pulses(1);
    repeat (8) @(negedge mclk_in);
    rd(0, 'h00d7, 8'h2c);
    check({7'h00, lirq}, 8'h01);
    bus(0, 1, 'h00d7, 8'h2c);
    rd(0, 'h00d7, 8'h2c);
    bus(0, 1, 'h00d7, 8'h24);
    rd(0, 'h00d7, 8'h24);
    bus(0, 1, 'h00d7, 8'h00);
    $display("Test legacy manual done");
    @(negedge mclk_in);
    i2c_en = 1'b1;
    addr(8'ha2, 1'b0);
    addr(8'hb0, 1'b0);
    rd(0, 'h00d7, 8'h00);
    addr(8'ha0, 1'b1);
    rd(0, 'h00d7, 8'h03);
    check({7'h00, swirq}, 8'h01);
    bus(0, 1, 'h00d7, 8'h10);
    rd(0, 'h00d7, 8'h11);
    addr(8'ha6, 1'b1);
    addr(8'hae, 1'b1);
    addr(8'hb6, 1'b0);
    bus(0, 1, 'h00d6, 8'h00);
    @(negedge mclk_in);
    txr = 1'b1;
    @(negedge mclk_in);
    txr = 1'b0;
    check(tx_data, 8'h30);
    rd(0, 'h00d6, 8'h01);
    @(negedge mclk_in);
    {rxv, rxf, rxd} = {2'b11, 8'h05};
    @(negedge mclk_in);
    {rxf, rxd} = {1'b0, 8'h5a};
    @(negedge mclk_in);
    rxv = 1'b0;
    rd(0, 'h00d6, 8'h06);
    bus(0, 1, 'h00d6, 8'h05);
    rd(0, 'h00d4, 8'h5a);
    $display("Test serial side done");
    complete_run();
  end
endmodule : test_display_data_channel_slave

`default_nettype wire
